// >>> sgf_pkg.sv
// sgf_pkg: constants and carrier types for the command/address front end.
// Assumes one sys_clk domain; every pad arrives asynchronous to it.
package sgf_pkg;
  localparam int ROW_W     = 13;
  localparam int BANK_W    = 4;
  localparam int COL_W_X32 = 6;
  localparam int COL_W_X16 = 7;
  localparam int APIN_W    = 9;
  localparam int LANES     = 4;
  localparam int PAIRS     = 2;
  localparam int A_AUTO    = 8;
  localparam int A_VAR_HI  = 11;
  localparam int A_VAR_LO  = 10;
  // Lanes are off (no termination) while in reset
  localparam logic [3:0] LANE_RST  = 4'h0;
  localparam logic [3:0] LANE_X32  = 4'hf;
  // Physical byte slots that stay on in x16 mode
  localparam logic [3:0] LANE_X16  = 4'hc;
  localparam logic [1:0] CFG_WAIT  = 2'h3;
  localparam logic [1:0] VAR_PLAIN = 2'h0;
  localparam logic [1:0] VAR_ONE   = 2'h1;
  localparam logic [1:0] VAR_TWO   = 2'h2;
  localparam logic [1:0] VAR_TRAIN = 2'h3;

  typedef enum logic [4:0] {
    CMD_NONE, CMD_MODE_REG_LOAD, CMD_ROW_OPEN, CMD_READ_BURST,
    CMD_READ_BURST_AUTOCLOSE, CMD_FIFO_PRELOAD, CMD_FIFO_TRAIN_READOUT,
    CMD_STORE_BURST, CMD_STORE_BURST_AUTOCLOSE, CMD_STORE_ONE_BYTE_MASKED,
    CMD_STORE_ONE_BYTE_MASKED_AUTOCLOSE, CMD_STORE_TWO_BYTE_MASKED,
    CMD_STORE_TWO_BYTE_MASKED_AUTOCLOSE, CMD_FIFO_DIRECT_STORE,
    CMD_CLOSE_BANK, CMD_CLOSE_ALL_BANKS, CMD_REFRESH,
    CMD_SELF_RESTORE_ENTRY, CMD_SELF_RESTORE_EXIT,
    CMD_SLEEP_ENTRY, CMD_SLEEP_EXIT
  } sgf_code_t;

  typedef enum logic [1:0] {PWR_ON, PWR_SLEEP, PWR_SELF} sgf_pwr_t;

  // Strobe balls, named by their meaning when not mirrored
  typedef struct packed {
    logic csN;
    logic weN;
    logic rasN;
    logic casN;
  } sgf_strobe_t;

  typedef struct packed {
    logic        ck;
    logic        ckN;
    logic [1:0]  forwarded_data_clock;
    logic [1:0]  wckN;
    sgf_strobe_t cmd;
    logic        ckeN;
    logic        abiN;
    logic [8:0]  addr;
    logic [31:0] dq;
    logic        mirror;
    logic        width;
  } sgf_pins_t;

  typedef struct packed {
    logic       valid;
    sgf_code_t  code;
    logic [3:0] bank;
    logic [12:0] addr;
    logic [6:0] column;
  } sgf_cmd_t;
endpackage

// >>> sgf_front_end.sv
// sgf_front_end: command/address front end of a graphics SDRAM.
// Assumes all pads are asynchronous to sys_clk and that the command
// clock and data clock run far slower than sys_clk.
//
// Overview of operation
// - Mirror strap swaps pin positions pairwise
// - Internal logic uses logical names only
// - x16 mode turns off two byte lanes
// - Width pin low means x16, high x32
// - Width latched four sys_clk cycles after reset release, then frozen
// - Commands sampled on true clock rise only
// - Address taken on both clock rises
// - Fixed bit order for each address half
// - Data captured on both data clock rises
// - Column six or seven bits, row thirteen
// - Bank and column from low address bits for transfers
// - Deselect and no-op change nothing while clock enable holds
// - All strobes low loads a mode register
// - Row strobe alone opens a row
// - Read with subcode 10 preloads FIFO
// - Refresh or self-refresh entry by clock enable
// - Inversion flag low inverts address bits
// - Training mode reads from strobes only
// - Reset clears all and disables termination
`timescale 1ns/1ps

module sgf_front_end (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // Device pads, as seen at the physical balls
  input  wire sgf_pkg::sgf_pins_t  pads,
  // Mode bits
  input  wire logic                addrInvEnable,
  input  wire logic                addrTrainMode,
  // Decoded commands
  output sgf_pkg::sgf_cmd_t        cmdOut,
  output sgf_pkg::sgf_pwr_t        pwrState,
  // Configuration
  output logic                     cfgDone,
  output logic                     mirrored,
  output logic                     x16Mode,
  output logic [3:0]               laneOn,
  // Captured data, logical byte order
  output logic [31:0]              dataTrue,
  output logic [31:0]              dataComp,
  output logic [1:0]               dataTrueStb,
  output logic [1:0]               dataCompStb
);

  localparam int PIN_W = $bits(sgf_pkg::sgf_pins_t);

  typedef struct packed {
    logic [PIN_W-1:0]     s1;
    logic [PIN_W-1:0]     s2;
    logic [PIN_W-1:0]     s3;
    logic [PIN_W-1:0]     lvl;
    logic [1:0]           cnt;
    logic                 cfg;
    logic                 mir;
    logic                 x16;
    logic [3:0]           lane;
    sgf_pkg::sgf_strobe_t cmd;
    logic                 ckeN;
    logic                 ckePrev;
    logic [8:0]           h1;
    logic                 pend;
    sgf_pkg::sgf_pwr_t    pwr;
    sgf_pkg::sgf_cmd_t    out;
    logic [31:0]          dT;
    logic [31:0]          dC;
    logic [1:0]           sT;
    logic [1:0]           sC;
  } sgf_state_t;

  sgf_state_t q;
  sgf_state_t n;

  // Swap the address balls that trade places under mirroring
  function automatic logic [8:0] mirAddr(input logic [8:0] a);
    logic [8:0] r;
    r    = a;
    r[0] = a[2];
    r[2] = a[0];
    r[1] = a[3];
    r[3] = a[1];
    r[5] = a[7];
    r[7] = a[5];
    r[6] = a[8];
    r[8] = a[6];
    return r;
  endfunction

  logic [PIN_W-1:0]     agree;
  logic [PIN_W-1:0]     newLvl;
  sgf_pkg::sgf_pins_t   pin;
  sgf_pkg::sgf_pins_t   old;
  sgf_pkg::sgf_strobe_t lc;
  logic [8:0]           la;
  logic                 ckRise;
  logic                 ckNRise;
  logic [12:0]          row;
  logic [3:0]           bank;
  logic [1:0]           vr;
  logic                 ap;
  logic                 sel;
  logic                 idle;
  logic [2:0]           strb;
  sgf_pkg::sgf_code_t   code;
  int                   pp;
  int                   pb;

  always_comb begin : nextState
    n = q;
    // Three-stage pad sampling; a level counts once stages 2 and 3 agree
    n.s1   = pads;
    n.s2   = q.s1;
    n.s3   = q.s2;
    agree  = ~(q.s2 ^ q.s3);
    newLvl = (agree & q.s3) | (~agree & q.lvl);
    n.lvl  = newLvl;
    pin    = sgf_pkg::sgf_pins_t'(newLvl);
    old    = sgf_pkg::sgf_pins_t'(q.lvl);
    n.out.valid = 1'b0;
    n.sT = 2'h0;
    n.sC = 2'h0;
    pp   = 0;
    pb   = 0;

    // Strap and width capture after reset release, then frozen
    if (!q.cfg) begin
      if (q.cnt == sgf_pkg::CFG_WAIT) begin
        n.cfg = 1'b1;
        n.mir = pin.mirror;
        n.x16 = ~pin.width;
        n.lane = pin.width ? sgf_pkg::LANE_X32 : sgf_pkg::LANE_X16;
      end else begin
        n.cnt = q.cnt + 2'h1;
      end
    end

    // Logical strobes and address from the physical balls
    lc.csN  = q.mir ? pin.cmd.weN  : pin.cmd.csN;
    lc.weN  = q.mir ? pin.cmd.csN  : pin.cmd.weN;
    lc.rasN = q.mir ? pin.cmd.casN : pin.cmd.rasN;
    lc.casN = q.mir ? pin.cmd.rasN : pin.cmd.casN;
    la = q.mir ? mirAddr(pin.addr) : pin.addr;
    if (addrInvEnable && !pin.abiN) begin
      la = ~la;
    end

    ckRise  = pin.ck & ~old.ck;
    ckNRise = pin.ckN & ~old.ckN;

    // First half: strobes, clock enable and upper address
    if (q.cfg && ckRise) begin
      n.cmd     = lc;
      n.ckePrev = q.ckeN;
      n.ckeN    = pin.ckeN;
      n.h1      = la;
      n.pend    = 1'b1;
    end

    // Second half assembles the logical address
    row  = {q.h1[4], q.h1[5], q.h1[6], q.h1[7], q.h1[8],
            la[8], la[5], la[2], la[1], la[0], la[3], la[7], la[6]};
    bank = {q.h1[0], q.h1[1], q.h1[2], q.h1[3]};
    vr   = row[sgf_pkg::A_VAR_HI:sgf_pkg::A_VAR_LO];
    ap   = row[sgf_pkg::A_AUTO];
    sel  = ~q.cmd.csN;
    strb = {q.cmd.rasN, q.cmd.casN, q.cmd.weN};
    idle = ~sel | (strb == 3'h7);
    code = sgf_pkg::CMD_NONE;

    if (q.cfg && q.pend && ckNRise) begin
      n.pend = 1'b0;
      case ({q.ckePrev, q.ckeN})
        2'b00: begin
          if (sel && q.pwr == sgf_pkg::PWR_ON) begin
            case (strb)
              3'h0: begin
                code = sgf_pkg::CMD_MODE_REG_LOAD;
              end
              3'h3: begin
                code = sgf_pkg::CMD_ROW_OPEN;
              end
              3'h1: begin
                code = sgf_pkg::CMD_REFRESH;
              end
              3'h2: begin
                code = ap ? sgf_pkg::CMD_CLOSE_ALL_BANKS
                          : sgf_pkg::CMD_CLOSE_BANK;
              end
              3'h5: begin
                if (addrTrainMode) begin
                  code = sgf_pkg::CMD_READ_BURST;
                end else begin
                  case (vr)
                    sgf_pkg::VAR_PLAIN,
                    sgf_pkg::VAR_ONE: begin
                      code = ap ? sgf_pkg::CMD_READ_BURST_AUTOCLOSE
                                : sgf_pkg::CMD_READ_BURST;
                    end
                    sgf_pkg::VAR_TWO: begin
                      if (!ap) begin
                        code = sgf_pkg::CMD_FIFO_PRELOAD;
                      end
                    end
                    default: begin
                      if (!ap) begin
                        code = sgf_pkg::CMD_FIFO_TRAIN_READOUT;
                      end
                    end
                  endcase
                end
              end
              3'h4: begin
                case (vr)
                  sgf_pkg::VAR_PLAIN: begin
                    code = ap ? sgf_pkg::CMD_STORE_BURST_AUTOCLOSE
                              : sgf_pkg::CMD_STORE_BURST;
                  end
                  sgf_pkg::VAR_ONE: begin
                    code = ap ? sgf_pkg::CMD_STORE_ONE_BYTE_MASKED_AUTOCLOSE
                              : sgf_pkg::CMD_STORE_ONE_BYTE_MASKED;
                  end
                  sgf_pkg::VAR_TWO: begin
                    code = ap ? sgf_pkg::CMD_STORE_TWO_BYTE_MASKED_AUTOCLOSE
                              : sgf_pkg::CMD_STORE_TWO_BYTE_MASKED;
                  end
                  default: begin
                    if (!ap) begin
                      code = sgf_pkg::CMD_FIFO_DIRECT_STORE;
                    end
                  end
                endcase
              end
              default: begin
                code = sgf_pkg::CMD_NONE;
              end
            endcase
          end
        end
        2'b01: begin
          if (idle && q.pwr == sgf_pkg::PWR_ON) begin
            code  = sgf_pkg::CMD_SLEEP_ENTRY;
            n.pwr = sgf_pkg::PWR_SLEEP;
          end else if (sel && strb == 3'h1 && q.pwr == sgf_pkg::PWR_ON) begin
            code  = sgf_pkg::CMD_SELF_RESTORE_ENTRY;
            n.pwr = sgf_pkg::PWR_SELF;
          end
        end
        2'b10: begin
          if (idle && q.pwr != sgf_pkg::PWR_ON) begin
            code  = (q.pwr == sgf_pkg::PWR_SELF) ? sgf_pkg::CMD_SELF_RESTORE_EXIT
                                                 : sgf_pkg::CMD_SLEEP_EXIT;
            n.pwr = sgf_pkg::PWR_ON;
          end
        end
        default: begin
          code = sgf_pkg::CMD_NONE;
        end
      endcase
      if (code != sgf_pkg::CMD_NONE) begin
        n.out.valid = 1'b1;
        n.out.code  = code;
        n.out.bank  = bank;
        n.out.addr  = row;
        n.out.column = q.x16 ? row[sgf_pkg::COL_W_X16-1:0]
                             : {1'b0, row[sgf_pkg::COL_W_X32-1:0]};
      end
    end

    // Data capture per clock pair on both data clock rises
    for (int p = 0; p < sgf_pkg::PAIRS; p++) begin
      pp = q.mir ? (sgf_pkg::PAIRS - 1 - p) : p;
      pb = q.mir ? (sgf_pkg::LANES - 1 - 2 * p) : 2 * p;
      if (q.cfg && q.lane[pb]) begin
        if (pin.forwarded_data_clock[pp] && !old.forwarded_data_clock[pp]) begin
          n.sT[p] = 1'b1;
          for (int b = 2 * p; b < 2 * p + 2; b++) begin
            pb = q.mir ? (sgf_pkg::LANES - 1 - b) : b;
            n.dT[8*b +: 8] = pin.dq[8*pb +: 8];
          end
        end
        if (pin.wckN[pp] && !old.wckN[pp]) begin
          n.sC[p] = 1'b1;
          for (int b = 2 * p; b < 2 * p + 2; b++) begin
            pb = q.mir ? (sgf_pkg::LANES - 1 - b) : b;
            n.dC[8*b +: 8] = pin.dq[8*pb +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q      <= '0;
      q.lane <= sgf_pkg::LANE_RST;
    end else begin
      q <= n;
    end
  end

  assign cmdOut      = q.out;
  assign pwrState    = q.pwr;
  assign cfgDone     = q.cfg;
  assign mirrored    = q.mir;
  assign x16Mode     = q.x16;
  assign laneOn      = q.lane;
  assign dataTrue    = q.dT;
  assign dataComp    = q.dC;
  assign dataTrueStb = q.sT;
  assign dataCompStb = q.sC;

endmodule // sgf_front_end

// >>> sgf_front_end_monitor.sv
// sgf_front_end_monitor: port assertions for the front end.
// Assumes a bind onto sgf_front_end; sees its ports only.
`timescale 1ns/1ps
module sgf_front_end_monitor (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               resetn,
  // Balls
  input wire sgf_pkg::sgf_pins_t pads,
  // Results
  input wire sgf_pkg::sgf_cmd_t  cmdOut,
  input wire logic               cfgDone,
  input wire logic               mirrored,
  input wire logic               x16Mode,
  input wire logic [3:0]         laneOn,
  input wire logic [1:0]         dataTrueStb,
  input wire logic [1:0]         dataCompStb
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_rst; disable iff (1'b0) !resetn |-> laneOn == 4'h0 && !cmdOut.valid; endproperty
  a_rst: assert property (p_rst) else $error("lanes on in reset");
  property p_frz; cfgDone && $past(cfgDone) |-> $stable(x16Mode) && $stable(mirrored); endproperty
  a_frz: assert property (p_frz) else $error("config moved");
  property p_lane; cfgDone |-> laneOn == (x16Mode ? sgf_pkg::LANE_X16 : sgf_pkg::LANE_X32); endproperty
  a_lane: assert property (p_lane) else $error("lane enables wrong");
  property p_wid; cfgDone |-> x16Mode == !pads.width && mirrored == pads.mirror; endproperty
  a_wid: assert property (p_wid) else $error("strap decode wrong");
  property p_col; cmdOut.valid && !x16Mode |-> !cmdOut.column[6]; endproperty
  a_col: assert property (p_col) else $error("x32 column too wide");
  property p_one; cmdOut.valid |=> !cmdOut.valid; endproperty
  a_one: assert property (p_one) else $error("valid too long");
  property p_cfg; !cfgDone |-> !cmdOut.valid && dataTrueStb == 2'h0 && dataCompStb == 2'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("output before config");
  property p_nop; cmdOut.valid |-> cmdOut.code != sgf_pkg::CMD_NONE; endproperty
  a_nop: assert property (p_nop) else $error("empty command");
  property p_lat; cmdOut.valid |-> $past(pads.ckN, 3) && !$past(pads.ckN, 12); endproperty
  a_lat: assert property (p_lat) else $error("valid not after second half");
endmodule // sgf_front_end_monitor

// >>> sgf_ctrl_model.sv
// sgf_ctrl_model: controller driving the command, address and data balls.
// Assumes the bench calls send one at a time.
`timescale 1ns/1ps
module sgf_ctrl_model (
  // Board straps
  input  wire logic          mir,
  input  wire logic          wid,
  // Balls
  output sgf_pkg::sgf_pins_t pads
);
  logic        ck = 1'b0;
  logic        forwarded_data_clock = 1'b0;
  logic [3:0]  cmd = 4'hf;
  logic        ckeN = 1'b0;
  logic        abiN = 1'b1;
  logic [8:0]  addr = 9'h000;
  logic [31:0] dq = 32'h0;
  always #80 ck = ~ck;
  always #40 forwarded_data_clock = ~forwarded_data_clock;
  // Straps pass straight through; the bench changes them only while reset is held
  assign pads = {ck, ~ck, {2{forwarded_data_clock}}, {2{~forwarded_data_clock}}, cmd, ckeN, abiN, addr, dq, mir, wid};
  function automatic logic [8:0] ball(logic [8:0] v);
    return mir ? {v[6], v[5], v[8], v[7], v[4], v[1], v[0], v[3], v[2]} : v;
  endfunction
  // s is {cs, ras, cas, we}, active low
  task automatic send(logic [3:0] s, logic k, logic inv, logic [3:0] b, logic [12:0] a);
    logic [8:0] h1;
    logic [8:0] h2;
    h1 = {a[8], a[9], a[10], a[11], a[12], b[0], b[1], b[2], b[3]};
    h2 = {a[7], a[1], a[0], a[6], 1'b0, a[2], a[5], a[4], a[3]};
    @(negedge ck);
    #40;
    cmd = mir ? {s[0], s[3], s[1], s[2]} : {s[3], s[0], s[2], s[1]};
    ckeN = k;
    abiN = ~inv;
    addr = ball(inv ? ~h1 : h1);
    @(posedge ck);
    #40;
    addr = ball(inv ? ~h2 : h2);
    @(negedge ck);
    #40;
    cmd = 4'hf;
    abiN = 1'b1;
    addr = ~addr;
  endtask
  task automatic put(logic [31:0] v);
    dq = v;
  endtask
endmodule // sgf_ctrl_model

// >>> sgf_front_end_tb.sv
// sgf_front_end_tb: self-checking bench for the front end.
// Assumes the controller model drives all balls.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module sgf_front_end_tb;
  logic               sys_clk;
  logic               resetn;
  logic               addrInvEnable;
  logic               addrTrainMode;
  logic               mir;
  logic               wid;
  sgf_pkg::sgf_pins_t pads;
  sgf_pkg::sgf_cmd_t  cmdOut;
  sgf_pkg::sgf_pwr_t  pwrState;
  logic               cfgDone;
  logic               mirrored;
  logic               x16Mode;
  logic [3:0]         laneOn;
  logic [31:0]        dataTrue;
  logic [31:0]        dataComp;
  logic [1:0]         dataTrueStb;
  logic [1:0]         dataCompStb;
  int                 num_errors = 0;
  int                 checks = 0;
  // Codes per read and write variant, index {A11, A10, A8}
  logic [4:0]         rd [8] = '{5'h03, 5'h04, 5'h03, 5'h04, 5'h05, 5'h00, 5'h06, 5'h00};
  logic [4:0]         wr [8] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h00};
  sgf_ctrl_model sgf_ctrl_model_inst (.mir(mir), .wid(wid), .pads(pads));
  sgf_front_end sgf_front_end_inst (.sys_clk(sys_clk), .resetn(resetn), .pads(pads),
    .addrInvEnable(addrInvEnable), .addrTrainMode(addrTrainMode), .cmdOut(cmdOut),
    .pwrState(pwrState), .cfgDone(cfgDone), .mirrored(mirrored), .x16Mode(x16Mode),
    .laneOn(laneOn), .dataTrue(dataTrue), .dataComp(dataComp),
    .dataTrueStb(dataTrueStb), .dataCompStb(dataCompStb));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic boot(logic m, logic w);
    @(negedge sys_clk);
    resetn = 1'b0;
    mir = m;
    wid = w;
    repeat (4) @(negedge sys_clk);
    `CHK(laneOn, 4'h0)
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK(cfgDone, 1'b1)
    `CHK(mirrored, m)
    `CHK(x16Mode, ~w)
    `CHK(laneOn, w ? sgf_pkg::LANE_X32 : sgf_pkg::LANE_X16)
  endtask
  task automatic t_cmd(logic [3:0] s, logic k, logic [12:0] a, logic [4:0] c);
    int n;
    n = 0;
    fork
      sgf_ctrl_model_inst.send(s, k, addrInvEnable, 4'hb, a);
      repeat (60) begin
        @(negedge sys_clk);
        if (cmdOut.valid === 1'b1)
          n++;
      end
    join
    `CHK(n, (c == 5'h00) ? 0 : 1)
    if (c != 5'h00) begin
      `CHK(cmdOut.code, sgf_pkg::sgf_code_t'(c))
      if (c inside {5'h01, 5'h02} || s[2:1] == 2'b10) begin
        `CHK(cmdOut.bank, 4'hb)
        `CHK(cmdOut.addr, a)
      end
      if (s[2:1] == 2'b10)
        `CHK(cmdOut.column, wid ? {1'b0, a[5:0]} : a[6:0])
    end
  endtask
  task automatic t_table();
    t_cmd(4'h0, 1'b0, 13'h0a5c, sgf_pkg::CMD_MODE_REG_LOAD);
    t_cmd(4'h3, 1'b0, 13'h1c35, sgf_pkg::CMD_ROW_OPEN);
    t_cmd(4'h7, 1'b0, 13'h1fff, sgf_pkg::CMD_NONE);
    t_cmd(4'h8, 1'b0, 13'h0000, sgf_pkg::CMD_NONE);
    t_cmd(4'h2, 1'b0, 13'h0e00, sgf_pkg::CMD_CLOSE_BANK);
    t_cmd(4'h2, 1'b0, 13'h0100, sgf_pkg::CMD_CLOSE_ALL_BANKS);
    t_cmd(4'h1, 1'b0, 13'h1234, sgf_pkg::CMD_REFRESH);
    for (int i = 0; i < 8; i++) begin
      t_cmd(4'h5, 1'b0, {1'b1, i[2:1], 1'b0, i[0], 8'h5a}, rd[i]);
      t_cmd(4'h4, 1'b0, {1'b1, i[2:1], 1'b0, i[0], 8'h5a}, wr[i]);
    end
  endtask
  // Disabled pairs never strobe and keep their reset value of zero
  task automatic t_data(logic [31:0] v);
    logic [31:0] e;
    logic [31:0] m;
    logic [1:0]  on;
    logic [1:0]  seen;
    on = wid ? 2'h3 : (mir ? 2'h1 : 2'h2);
    m = {{16{on[1]}}, {16{on[0]}}};
    e = (mir ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v) & m;
    seen = 2'h0;
    sgf_ctrl_model_inst.put(v);
    repeat (40) begin
      @(negedge sys_clk);
      seen = seen | dataTrueStb | dataCompStb;
    end
    `CHK(seen, on)
    `CHK(dataTrue, e)
    `CHK(dataComp, e)
  endtask
  task automatic t_pwr();
    t_cmd(4'h7, 1'b1, 13'h0000, sgf_pkg::CMD_SLEEP_ENTRY);
    `CHK(pwrState, sgf_pkg::PWR_SLEEP)
    t_cmd(4'h8, 1'b0, 13'h0000, sgf_pkg::CMD_SLEEP_EXIT);
    `CHK(pwrState, sgf_pkg::PWR_ON)
    t_cmd(4'h1, 1'b1, 13'h0000, sgf_pkg::CMD_SELF_RESTORE_ENTRY);
    `CHK(pwrState, sgf_pkg::PWR_SELF)
    t_cmd(4'h7, 1'b0, 13'h0000, sgf_pkg::CMD_SELF_RESTORE_EXIT);
    `CHK(pwrState, sgf_pkg::PWR_ON)
  endtask
  task automatic t_mode();
    @(negedge sys_clk);
    addrInvEnable = 1'b1;
    t_cmd(4'h3, 1'b0, 13'h0b37, sgf_pkg::CMD_ROW_OPEN);
    t_cmd(4'h5, 1'b0, 13'h0143, sgf_pkg::CMD_READ_BURST_AUTOCLOSE);
    @(negedge sys_clk);
    addrInvEnable = 1'b0;
    addrTrainMode = 1'b1;
    t_cmd(4'h5, 1'b0, 13'h0c21, sgf_pkg::CMD_READ_BURST);
    t_cmd(4'h5, 1'b0, 13'h0921, sgf_pkg::CMD_READ_BURST);
    @(negedge sys_clk);
    addrTrainMode = 1'b0;
  endtask
  initial begin
    resetn = 1'b0;
    addrInvEnable = 1'b0;
    addrTrainMode = 1'b0;
    mir = 1'b0;
    wid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      boot(i[1], i[0]);
      t_table();
      t_data(32'h1234abcd);
    end
    t_pwr();
    t_mode();
    final_report();
  end
  initial begin
    #200000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // sgf_front_end_tb
bind sgf_front_end sgf_front_end_monitor sgf_front_end_monitor_inst (.sys_clk(sys_clk),
  .resetn(resetn), .pads(pads), .cmdOut(cmdOut), .cfgDone(cfgDone), .mirrored(mirrored),
  .x16Mode(x16Mode), .laneOn(laneOn), .dataTrueStb(dataTrueStb), .dataCompStb(dataCompStb));
